// ===== sscr_consts.vh
// Purpose: constants for the stepper serial control register bank
// Assumes: 8-bit registers, 5-bit register address, msb first
// Notes:   field positions name bits inside each control byte
`ifndef SSCR_CONSTS_VH
`define SSCR_CONSTS_VH
`define SSCR_ADDR_WATCHDOG     5'h00
`define SSCR_ADDR_STEP_CUR     5'h01
`define SSCR_ADDR_DIR_SLOPE    5'h02
`define SSCR_ADDR_ENABLE_SLEEP 5'h03
`define SSCR_ADDR_STATUS0      5'h04
`define SSCR_ADDR_STATUS3      5'h07
`define SSCR_ADDR_REG_TUNE     5'h08
`define SSCR_REG_RESET         8'h00
`define SSCR_BYTE_BITS         4'h8
`define SSCR_PACKET_BITS       5'h10
`define SSCR_CMD_BIT           7
`define SSCR_ADDR_MSB          4
`define SSCR_WD_EN_BIT         7
`define SSCR_WD_INT_MSB        6
`define SSCR_WD_INT_LSB        3
`define SSCR_SM_MSB            7
`define SSCR_SM_LSB            5
`define SSCR_CUR_MSB           4
`define SSCR_CUR_LSB           0
`define SSCR_DIRINV_BIT        7
`define SSCR_STEPPOL_BIT       6
`define SSCR_FREQ_BIT          3
`define SSCR_JITTER_BIT        2
`define SSCR_SLOPE_MSB         1
`define SSCR_SLOPE_LSB         0
`define SSCR_DRVEN_BIT         7
`define SSCR_SLEEP_BIT         6
`define SSCR_LAGAIN_BIT        5
`define SSCR_LATRANS_BIT       4
`define SSCR_VAR_MSB           7
`define SSCR_VAR_LSB           6
`define SSCR_BLANK_MSB         5
`define SSCR_BLANK_LSB         4
`define SSCR_SWTIME_BIT        2
`define SSCR_BRIDGE_MSB        1
`define SSCR_BRIDGE_LSB        0
`endif

// ===== sscr_sync.v
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module sscr_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  // plain double flop, reset to idle-low
  always @(posedge clk)
  begin
    if (reset)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ===== sscr_regs.v
// Purpose: serial-slave control register bank of a micro-stepping driver
// Assumes: serial clock far slower than clk, mode 0, chip select active low
// Notes:   all link pins are sampled by clk and edges found from the samples
`timescale 1ns/1ns
`include "sscr_consts.vh"
module sscr_regs
(
  input  wire       clk,
  input  wire       reset,
  input  wire       cs_n,
  input  wire       sclk,
  input  wire       sdi,
  output reg        sdo,
  output reg        sdo_oe_n,
  input  wire       dir_pin,
  input  wire       step_advance_pin,
  input  wire [7:0] status0_in,
  input  wire [7:0] status1_in,
  input  wire [7:0] status2_in,
  input  wire [7:0] status3_in,
  output reg        step_pulse,
  output reg        dir_ccw,
  output reg        watchdog_enable_bit,
  output reg  [3:0] watchdog_interval_sel,
  output reg  [2:0] step_resolution_sel,
  output reg  [4:0] coil_current_sel,
  output reg  [1:0] slope_select,
  output reg        pwm_freq_double,
  output reg        pwm_jitter_en,
  output reg        driver_enable,
  output reg        sleep_mode,
  output reg        load_angle_quarter_gain,
  output reg        load_angle_output_en,
  output reg  [1:0] reduced_duty_variant,
  output reg  [1:0] comparator_blank_time,
  output reg        duty_limit_75,
  output reg  [1:0] comp_bridge_time
);
  reg  [7:0] reg_watchdog;
  reg  [7:0] reg_step_cur;
  reg  [7:0] reg_dir_slope;
  reg  [7:0] reg_enable_sleep;
  reg  [7:0] reg_tune;
  reg  [7:0] status_hold [0:3];
  reg  [7:0] shift_in;
  reg  [7:0] shift_out;
  reg  [4:0] bit_count;
  reg  [4:0] addr;
  reg        wr_cmd;
  reg  [7:0] wr_data;
  reg        data_next;
  reg        sclk_d;
  reg        cs_n_d;
  reg        step_d;
  wire       cs_sel_s;
  wire       cs_n_s;
  wire       sclk_s;
  wire       sdi_s;
  wire       dir_s;
  wire       step_s;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       cs_rise;
  wire [7:0] load_value;
  wire [7:0] next_shift_in;
  integer    i;

  // every pin crosses two flops before use; select goes through inverted
  // so that the cleared synchroniser reads as deselected, otherwise the
  // first cycles after reset would look like a select and drive sdo
  sscr_sync #(.WIDTH(5)) u_sync
  (
    .clk      (clk),
    .reset    (reset),
    .async_in ({~cs_n, sclk, sdi, dir_pin, step_advance_pin}),
    .sync_out ({cs_sel_s, sclk_s, sdi_s, dir_s, step_s})
  );

  // register readout; status reads come from the snapshot, unmapped addresses read back as zero
  function [7:0] read_reg;
    input [4:0] a;
    begin
      case (a)
        `SSCR_ADDR_WATCHDOG:     read_reg = reg_watchdog;
        `SSCR_ADDR_STEP_CUR:     read_reg = reg_step_cur;
        `SSCR_ADDR_DIR_SLOPE:    read_reg = reg_dir_slope;
        `SSCR_ADDR_ENABLE_SLEEP: read_reg = reg_enable_sleep;
        `SSCR_ADDR_REG_TUNE:     read_reg = reg_tune;
        default:
        begin
          if (a >= `SSCR_ADDR_STATUS0 && a <= `SSCR_ADDR_STATUS3)
            read_reg = status_hold[a[1:0]];
          else
            read_reg = `SSCR_REG_RESET;
        end
      endcase
    end
  endfunction

  assign cs_n_s        = ~cs_sel_s;
  // addr already holds the latest command when a byte's last fall arrives
  assign load_value    = read_reg(addr);
  assign sclk_rise     = ~cs_n_s & sclk_s & ~sclk_d;
  assign sclk_fall     = ~cs_n_s & ~sclk_s & sclk_d;
  assign cs_rise       = cs_n_s & ~cs_n_d;
  assign next_shift_in = {shift_in[6:0], sdi_s};

  // edge history of sampled pins
  always @(posedge clk)
  begin
    if (reset)
    begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      step_d <= 1'b0;
    end
    else
    begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      step_d <= step_s;
    end
  end

  // status snapshot moves only while deselected, so every read in a frame may be stale
  always @(posedge clk)
  begin
    if (reset)
    begin
      for (i = 0; i < 4; i = i + 1)
        status_hold[i] <= `SSCR_REG_RESET;
    end
    else if (cs_n_s)
    begin
      status_hold[0] <= status0_in;
      status_hold[1] <= status1_in;
      status_hold[2] <= status2_in;
      status_hold[3] <= status3_in;
    end
  end

  // serial engine: count bits, capture command/address/data, drive sdo
  always @(posedge clk)
  begin
    if (reset)
    begin
      shift_in  <= `SSCR_REG_RESET;
      shift_out <= `SSCR_REG_RESET;
      bit_count <= 5'h00;
      addr      <= 5'h00;
      wr_cmd    <= 1'b0;
      wr_data   <= `SSCR_REG_RESET;
      data_next <= 1'b0;
      sdo       <= 1'b1;
      sdo_oe_n  <= 1'b1;
    end
    else
    begin
      sdo_oe_n <= cs_n_s;
      if (cs_n_s)
      begin
        bit_count <= 5'h00;
        data_next <= 1'b0;
      end
      else
      begin
        if (cs_n_d)
          sdo <= shift_out[7];
        if (sclk_rise)
        begin
          shift_in <= next_shift_in;
          // saturate so over-long packets stay distinguishable
          if (bit_count != 5'h1F)
            bit_count <= bit_count + 5'h01;
          if (bit_count[2:0] == 3'h7)
          begin
            // a write's data byte is no command; every other byte is one
            if (data_next)
            begin
              wr_data   <= next_shift_in;
              data_next <= 1'b0;
            end
            else
            begin
              if (bit_count[4:3] == 2'h0)
                wr_cmd <= next_shift_in[`SSCR_CMD_BIT];
              addr      <= next_shift_in[`SSCR_ADDR_MSB:0];
              data_next <= next_shift_in[`SSCR_CMD_BIT];
            end
          end
        end
        if (sclk_fall)
        begin
          // last fall of a byte reloads from the latest address; before
          // that the buffer still holds the previously loaded content
          if (bit_count[2:0] == 3'h0 && bit_count != 5'h00)
          begin
            shift_out <= load_value;
            sdo       <= load_value[7];
          end
          else
          begin
            shift_out <= {shift_out[6:0], 1'b0};
            sdo       <= shift_out[6];
          end
        end
      end
    end
  end

  // commit on deselect only for an exact sixteen-bit write
  always @(posedge clk)
  begin
    if (reset)
    begin
      reg_watchdog     <= `SSCR_REG_RESET;
      reg_step_cur     <= `SSCR_REG_RESET;
      reg_dir_slope    <= `SSCR_REG_RESET;
      reg_enable_sleep <= `SSCR_REG_RESET;
      reg_tune         <= `SSCR_REG_RESET;
    end
    else if (cs_rise && wr_cmd && bit_count == `SSCR_PACKET_BITS)
    begin
      case (addr)
        `SSCR_ADDR_WATCHDOG:     reg_watchdog     <= wr_data;
        `SSCR_ADDR_STEP_CUR:     reg_step_cur     <= wr_data;
        `SSCR_ADDR_DIR_SLOPE:    reg_dir_slope    <= wr_data;
        `SSCR_ADDR_ENABLE_SLEEP: reg_enable_sleep <= wr_data;
        `SSCR_ADDR_REG_TUNE:     reg_tune         <= wr_data;
        default:                 reg_tune         <= reg_tune;    // read-only ignored
      endcase
    end
  end

  // field decode into registered control outputs
  always @(posedge clk)
  begin
    if (reset)
    begin
      step_pulse              <= 1'b0;
      dir_ccw                 <= 1'b0;
      watchdog_enable_bit     <= 1'b0;
      watchdog_interval_sel   <= 4'h0;
      step_resolution_sel     <= 3'h0;
      coil_current_sel        <= 5'h00;
      slope_select            <= 2'h0;
      pwm_freq_double         <= 1'b0;
      pwm_jitter_en           <= 1'b0;
      driver_enable           <= 1'b0;
      sleep_mode              <= 1'b0;
      load_angle_quarter_gain <= 1'b0;
      load_angle_output_en    <= 1'b0;
      reduced_duty_variant    <= 2'h0;
      comparator_blank_time   <= 2'h0;
      duty_limit_75           <= 1'b0;
      comp_bridge_time        <= 2'h0;
    end
    else
    begin
      sleep_mode <= reg_enable_sleep[`SSCR_SLEEP_BIT];
      // step input is ignored while asleep; direction still follows dir_pin
      step_pulse <= ~reg_enable_sleep[`SSCR_SLEEP_BIT] &
                    (reg_dir_slope[`SSCR_STEPPOL_BIT] ? (step_d & ~step_s)
                                                      : (~step_d & step_s));
      dir_ccw <= dir_s ^ reg_dir_slope[`SSCR_DIRINV_BIT];
      watchdog_enable_bit   <= reg_watchdog[`SSCR_WD_EN_BIT];
      watchdog_interval_sel <= reg_watchdog[`SSCR_WD_INT_MSB:`SSCR_WD_INT_LSB];
      step_resolution_sel   <= reg_step_cur[`SSCR_SM_MSB:`SSCR_SM_LSB];
      coil_current_sel      <= reg_step_cur[`SSCR_CUR_MSB:`SSCR_CUR_LSB];
      slope_select     <= reg_dir_slope[`SSCR_SLOPE_MSB:`SSCR_SLOPE_LSB];
      pwm_freq_double  <= reg_dir_slope[`SSCR_FREQ_BIT];
      pwm_jitter_en    <= reg_dir_slope[`SSCR_JITTER_BIT];
      // bridges stay off in sleep even if enabled
      driver_enable    <= reg_enable_sleep[`SSCR_DRVEN_BIT] &
                          ~reg_enable_sleep[`SSCR_SLEEP_BIT];
      load_angle_quarter_gain <= reg_enable_sleep[`SSCR_LAGAIN_BIT];
      load_angle_output_en    <= ~reg_enable_sleep[`SSCR_LATRANS_BIT];
      reduced_duty_variant  <= reg_tune[`SSCR_VAR_MSB:`SSCR_VAR_LSB];
      comparator_blank_time <= reg_tune[`SSCR_BLANK_MSB:`SSCR_BLANK_LSB];
      duty_limit_75         <= reg_tune[`SSCR_SWTIME_BIT];
      comp_bridge_time      <= reg_tune[`SSCR_BRIDGE_MSB:`SSCR_BRIDGE_LSB];
    end
  end
endmodule

// ===== sscr_regs_chk_assertions.sv
// Purpose: port-level checks for the serial control register bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   margins allow for the pin synchronisers
`timescale 1ns/1ns
module sscr_regs_chk
(
  input wire       clk,
  input wire       reset,
  input wire       cs_n,
  input wire       sclk,
  input wire       sdo,
  input wire       sdo_oe_n,
  input wire       step_pulse,
  input wire       driver_enable,
  input wire       sleep_mode,
  input wire [2:0] step_resolution_sel,
  input wire [4:0] coil_current_sel
);
  reg [3:0] since_fall;
  reg [3:0] cs_low;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // saturating ages of the last serial clock fall and of the selection
  always @(posedge clk)
  begin
    since_fall <= (reset || $fell(sclk)) ? 4'h0 : since_fall + {3'h0, ~&since_fall};
    cs_low     <= (reset || cs_n) ? 4'h0 : cs_low + {3'h0, ~&cs_low};
  end
  property p_oe_idle; cs_n [*4] |-> sdo_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while idle");
  property p_oe_drive; !cs_n [*5] |-> !sdo_oe_n; endproperty
  a_oe_drive: assert property (p_oe_drive) else $error("sdo not driven");
  property p_sdo_fall; $changed(sdo) && cs_low > 4'h9 |-> since_fall < 4'h8; endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved off a fall");
  property p_sleep_drv; sleep_mode |-> !driver_enable; endproperty
  a_sleep_drv: assert property (p_sleep_drv) else $error("bridge on in sleep");
  property p_sleep_step; sleep_mode |-> !step_pulse; endproperty
  a_sleep_step: assert property (p_sleep_step) else $error("step in sleep");
  property p_step_once; step_pulse |=> !step_pulse; endproperty
  a_step_once: assert property (p_step_once) else $error("step pulse too long");
  property p_hold; !cs_n [*8] |-> $stable({coil_current_sel, step_resolution_sel}); endproperty
  a_hold: assert property (p_hold) else $error("register moved while selected");
  property p_rst; $fell(reset) |-> sdo_oe_n && !driver_enable && !coil_current_sel; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind sscr_regs sscr_regs_chk sscr_regs_chk_i (.*);

// ===== sscr_master.sv
// Purpose: serial bus master model for the register bank link
// Assumes: mode 0, msb first, 800 ns serial clock period
// Notes:   sdo is sampled late in the high phase, where it has settled
`timescale 1ns/1ns
module sscr_master
(
  input  wire clk,
  input  wire sdo_line,
  output reg  cs_n,
  output reg  sclk,
  output reg  sdi
);
  // idle: deselected, clock parked low between frames
  initial {cs_n, sclk, sdi} = 3'b100;
  // step n system clocks, landing just after a rising edge
  task automatic wclk(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one frame of n bits msb first; writes use exactly sixteen
  task automatic xfer(input [31:0] tx, input integer n, output [31:0] rx);
    integer i;
    rx = 32'h0;
    cs_n = 1'b0;
    wclk(8);
    for (i = n - 1; i >= 0; i = i - 1)
    begin
      sdi = tx[i];
      wclk(4);
      sclk = 1'b1;
      wclk(4);
      rx = {rx[30:0], sdo_line};
      sclk = 1'b0;
    end
    wclk(4);
    cs_n = 1'b1;
    sdi = ~sdi;
    wclk(8);
  endtask
endmodule

// ===== sscr_regs_tb_top.sv
// Purpose: self-checking bench for the serial control register bank
// Assumes: reserved bits are written as zero
// Notes:   status sources derive from one bench register changed mid-frame
`timescale 1ns/1ns
`include "sscr_consts.vh"
module sscr_regs_tb_top;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         dir_pin = 1'b0;
  reg         step_advance_pin = 1'b0;
  reg  [7:0]  status0_in = 8'hA5;
  reg  [7:0]  img [0:4];
  reg  [7:0]  d;
  reg  [7:0]  pulses = 8'h00;
  reg  [7:0]  p0;
  reg  [31:0] rx;
  reg  [3:0]  k;
  reg  [2:0]  r;
  integer     mismatches = 0;
  integer     check_count = 0;
  integer     cycles = 0;
  wire        cs_n, sclk, sdi, sdo, sdo_oe_n, step_pulse, dir_ccw, watchdog_enable_bit;
  wire        pwm_freq_double, pwm_jitter_en, driver_enable, sleep_mode, duty_limit_75;
  wire        load_angle_quarter_gain, load_angle_output_en;
  wire [3:0]  watchdog_interval_sel;
  wire [2:0]  step_resolution_sel;
  wire [4:0]  coil_current_sel;
  wire [1:0]  slope_select, reduced_duty_variant, comparator_blank_time, comp_bridge_time;
  wire [7:0]  status1_in = ~status0_in;
  wire [7:0]  status2_in = status0_in ^ 8'h5A;
  wire [7:0]  status3_in = {status0_in[0], status0_in[7:1]};
  // a deselected output floats to the pull-up
  wire        sdo_line = sdo_oe_n ? 1'b1 : sdo;
  always #50 clk = ~clk;
  sscr_regs sscr_regs_i
  (
    .clk (clk), .reset (reset), .cs_n (cs_n), .sclk (sclk), .sdi (sdi), .sdo (sdo),
    .sdo_oe_n (sdo_oe_n), .dir_pin (dir_pin), .step_advance_pin (step_advance_pin),
    .status0_in (status0_in), .status1_in (status1_in), .status2_in (status2_in),
    .status3_in (status3_in), .step_pulse (step_pulse), .dir_ccw (dir_ccw),
    .watchdog_enable_bit (watchdog_enable_bit), .watchdog_interval_sel (watchdog_interval_sel),
    .step_resolution_sel (step_resolution_sel), .coil_current_sel (coil_current_sel),
    .slope_select (slope_select), .pwm_freq_double (pwm_freq_double),
    .pwm_jitter_en (pwm_jitter_en), .driver_enable (driver_enable), .sleep_mode (sleep_mode),
    .load_angle_quarter_gain (load_angle_quarter_gain),
    .load_angle_output_en (load_angle_output_en), .reduced_duty_variant (reduced_duty_variant),
    .comparator_blank_time (comparator_blank_time), .duty_limit_75 (duty_limit_75),
    .comp_bridge_time (comp_bridge_time)
  );
  sscr_master sscr_master_i
  (
    .clk (clk), .sdo_line (sdo_line), .cs_n (cs_n), .sclk (sclk), .sdi (sdi)
  );
  // count step pulses and cut a hang short
  always @(posedge clk)
  begin
    pulses <= pulses + {7'h0, step_pulse === 1'b1};
    cycles = cycles + 1;
    if (cycles == 30000)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end
  task results;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string w, input [7:0] e, input [7:0] g);
    check_count = check_count + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("unexpected %0s: expected %h, seen %h", w, e, g);
    end
  endtask
  // writable bits of each register; the rest are left zero
  function [7:0] msk(input [2:0] n);
    msk = n == 3'h0 ? 8'hF8 : n == 3'h2 ? 8'hCF : n == 3'h3 ? 8'hF0 : n == 3'h4 ? 8'hF7 : 8'hFF;
  endfunction
  function [4:0] ad(input [2:0] n);
    ad = n == 3'h4 ? `SSCR_ADDR_REG_TUNE : {2'h0, n};
  endfunction
  // decoded outputs follow the image; sleep forces the bridge off
  task fields;
    chk("wd", img[0], {watchdog_enable_bit, watchdog_interval_sel, 3'h0});
    chk("mode", img[1], {step_resolution_sel, coil_current_sel});
    chk("slope", img[2] & 8'h0F, {4'h0, pwm_freq_double, pwm_jitter_en, slope_select});
    chk("drv", {img[3][7] & ~img[3][6], img[3][6:5], ~img[3][4], 4'h0}, {driver_enable,
      sleep_mode, load_angle_quarter_gain, load_angle_output_en, 4'h0});
    chk("tune", img[4], {reduced_duty_variant, comparator_blank_time, 1'b0, duty_limit_75,
      comp_bridge_time});
  endtask
  initial
  begin
    for (r = 0; r < 5; r = r + 1)
      img[r] = 8'h00;
    sscr_master_i.wclk(3);
    reset = 1'b0;
    sscr_master_i.wclk(4);
    fields;
    // eight codes per register, the old value echoed each time
    for (k = 0; k < 8; k = k + 1)
    begin
      for (r = 0; r < 5; r = r + 1)
      begin
        d = ({k[2:0], ~k[2:0], k[1:0]} ^ (8'h3B * {5'h0, r})) & msk(r);
        sscr_master_i.xfer({16'h0, 3'h4, ad(r), d}, 16, rx);
        chk("echo", img[r], rx[7:0]);
        sscr_master_i.xfer({16'h0, 3'h0, ad(r), 8'h00}, 16, rx);
        chk("old", img[r], rx[15:8]);
        chk("new", d, rx[7:0]);
        img[r] = d;
      end
      fields;
      dir_pin = 1'b1;
      sscr_master_i.wclk(6);
      chk("dir", {7'h0, ~img[2][7]}, {7'h0, dir_ccw});
      dir_pin = 1'b0;
      p0 = pulses;
      step_advance_pin = 1'b1;
      sscr_master_i.wclk(8);
      chk("rise", {7'h0, ~img[2][6] & ~img[3][6]}, pulses - p0);
      chk("dir", {7'h0, img[2][7]}, {7'h0, dir_ccw});
      p0 = pulses;
      step_advance_pin = 1'b0;
      sscr_master_i.wclk(8);
      chk("fall", {7'h0, img[2][6] & ~img[3][6]}, pulses - p0);
    end
    // short and long write frames leave the register alone
    sscr_master_i.xfer({16'h0, 3'h4, 5'h01, ~img[1]} >> 1, 15, rx);
    sscr_master_i.xfer({15'h0, 3'h4, 5'h01, ~img[1], 1'b1}, 17, rx);
    sscr_master_i.xfer({8'h0, 3'h0, 5'h01, 3'h0, 5'h09, 8'h00}, 24, rx);
    chk("short", img[1], rx[15:8]);
    chk("unmapped", 8'h00, rx[7:0]);
    // the snapshot holds while selected, refreshes once released
    fork
      sscr_master_i.xfer({8'h0, 3'h0, 5'h04, 3'h0, 5'h07, 8'h00}, 24, rx);
      begin
        sscr_master_i.wclk(60);
        status0_in = 8'h3C;
      end
    join
    chk("stale", 8'hA5, rx[15:8]);
    chk("stale", 8'hD2, rx[7:0]);
    sscr_master_i.xfer({3'h0, 5'h04, 3'h0, 5'h05, 3'h0, 5'h06, 8'h00}, 32, rx);
    chk("status0", 8'h3C, rx[23:16]);
    chk("status1", 8'hC3, rx[15:8]);
    chk("status2", 8'h66, rx[7:0]);
    results;
  end
endmodule
